// *** rtl/spp_defines.vh ***
`ifndef SPP_DEFINES_VH
`define SPP_DEFINES_VH

// Register word indices, matched against address bits 5:2
`define SPP_ADDR_CTRL 4'h0
`define SPP_ADDR_PKT_LEN 4'h1
`define SPP_ADDR_GAP 4'h2
`define SPP_ADDR_HOLDOFF 4'h3
`define SPP_ADDR_PAYLOAD 4'h4
`define SPP_ADDR_TICK_RATE 4'h5
`define SPP_ADDR_BANDWIDTH 4'h6
`define SPP_ADDR_STATUS 4'h7

// Reset values
`define SPP_PKT_LEN_RST 16'h05DC
`define SPP_GAP_RST 32'h00000000
`define SPP_HOLDOFF_RST 32'h00000000

// Framing constants
`define SPP_HDR_BYTES 16'h0024
`define SPP_LEADER_BYTES 16'h0024
`define SPP_TRAILER_BYTES 16'h0024

// Timing: one tick is 8 ns, clock runs at 4 ns
`define SPP_TICK_NS 8
`define SPP_CLK_NS 4
`define SPP_CLKS_PER_TICK (`SPP_TICK_NS / `SPP_CLK_NS)
`define SPP_TICKS_PER_SEC 32'h07735940

// Control bit positions
`define SPP_CTRL_EN 0

`endif

// *** rtl/spp_fifo.v ***
`timescale 1ns/1ps
module spp_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 8,
    parameter AW = 3
) (
    input wire clk_i, // Clock
    input wire rst_i, // Sync reset
    input wire [WIDTH-1:0] in_data_i, // Write data
    input wire in_valid_i, // Write valid
    output wire in_ready_o, // Not full
    output wire [WIDTH-1:0] out_data_o, // Read data
    output wire out_valid_o, // Not empty
    input wire out_ready_i // Consumer ready
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wr_ptr;
    reg [AW-1:0] rd_ptr;
    reg [AW:0] count;
    wire push;
    wire pop;

    assign in_ready_o = (count != DEPTH[AW:0]);
    assign out_valid_o = (count != {(AW+1){1'b0}});
    assign out_data_o = mem[rd_ptr];
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;

    always @(posedge clk_i)
    begin
        if (push)
        begin
            mem[wr_ptr] <= in_data_i;
        end
        if (rst_i)
        begin
            wr_ptr <= {AW{1'b0}};
            rd_ptr <= {AW{1'b0}};
            count <= {(AW+1){1'b0}};
        end
        else
        begin
            if (push)
            begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (pop)
            begin
                rd_ptr <= rd_ptr + 1'b1;
            end
            if (push && !pop)
            begin
                count <= count + 1'b1;
            end
            else if (pop && !push)
            begin
                count <= count - 1'b1;
            end
        end
    end
endmodule // spp_fifo

// *** rtl/spp_bw_div.v ***
`timescale 1ns/1ps
// Sequential restoring divider, one quotient bit per clock
module spp_bw_div #(
    parameter W = 48
) (
    input wire clk_i, // Clock
    input wire rst_i, // Sync reset
    input wire start_i, // Start pulse
    input wire [W-1:0] num_i, // Dividend
    input wire [W-1:0] den_i, // Divisor
    output reg [W-1:0] quo_o, // Quotient, held
    output reg done_o // One-cycle done pulse
);
    reg [W-1:0] rem;
    reg [W-1:0] q;
    reg [W-1:0] d;
    reg [7:0] cnt;
    reg busy;
    wire [W:0] trial;

    assign trial = {rem, q[W-1]} - {1'b0, d};

    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            rem <= {W{1'b0}};
            q <= {W{1'b0}};
            d <= {W{1'b0}};
            cnt <= 8'h00;
            busy <= 1'b0;
            quo_o <= {W{1'b0}};
            done_o <= 1'b0;
        end
        else
        begin
            done_o <= 1'b0;
            if (start_i && !busy)
            begin
                rem <= {W{1'b0}};
                q <= num_i;
                d <= den_i;
                cnt <= W[7:0];
                busy <= 1'b1;
            end
            else if (busy)
            begin
                if (trial[W])
                begin
                    rem <= {rem[W-2:0], q[W-1]};
                    q <= {q[W-2:0], 1'b0};
                end
                else
                begin
                    rem <= trial[W-1:0];
                    q <= {q[W-2:0], 1'b1};
                end
                cnt <= cnt - 8'h01;
                if (cnt == 8'h01)
                begin
                    busy <= 1'b0;
                    done_o <= 1'b1;
                    quo_o <= (d == {W{1'b0}}) ? {W{1'b0}} :
                        (trial[W] ? {q[W-2:0], 1'b0} : {q[W-2:0], 1'b1});
                end
            end
        end
    end
endmodule // spp_bw_div

// *** rtl/spp_pacer.v ***
// Chosen here: the placing of the registers and register access over Wishbone.
`timescale 1ns/1ps
`include "spp_defines.vh"
// What this block does
// [RQ1] Read-only frame payload byte count, no headers
// [RQ2] Frame sent as leader, payloads, trailer
// [RQ3] Packet length sets payload packets only
// [RQ4] Full payload data is length minus 36
// [RQ5] Programmable tick gap between every packet
// [RQ6] One tick lasts 8 ns
// [RQ7] Readable tick rate in ticks per second
// [RQ8] Frame start held off programmable ticks
// [RQ9] Host keeps holdoff zero unless staggering
// [RQ10] Read-only bandwidth from length and gap
// [RQ11] One byte sent per tick
// [RQ12] Host packet timeout exceeds the gap
// [RQ13] Host keeps summed bandwidth below 125 MB/s
// [RQ14] Bandwidth is bytes over bytes-plus-gaps time
module spp_pacer #(
    parameter FIFO_DEPTH = 8,
    parameter FIFO_AW = 3
) (
    input wire clk_i, // Clock, 250 MHz
    input wire rst_i, // Sync reset, active high
    input wire [31:0] wb_adr_i, // Wishbone byte address
    input wire [31:0] wb_dat_i, // Wishbone write data
    output reg [31:0] wb_dat_o, // Wishbone read data
    input wire wb_we_i, // Write enable
    input wire [3:0] wb_sel_i, // Byte selects
    input wire wb_cyc_i, // Cycle
    input wire wb_stb_i, // Strobe
    output reg wb_ack_o, // Acknowledge
    input wire [31:0] frame_bytes_i, // Image plus chunk bytes per frame
    input wire frame_ready_i, // Frame acquired, level until taken
    output wire frame_take_o, // Frame accepted, pulse
    input wire [7:0] img_data_i, // Image byte
    input wire img_valid_i, // Image byte valid
    output wire img_ready_o, // FIFO can accept
    output reg [7:0] tx_data_o, // Transmit byte
    output reg tx_valid_o, // Transmit byte valid
    output reg tx_sop_o, // First byte of packet
    output reg tx_eop_o, // Last byte of packet
    output reg [1:0] tx_kind_o // 0 leader, 1 payload, 2 trailer
);
    // =========================================================
    // Registers
    // =========================================================
    reg enable;
    reg [15:0] stream_packet_length;
    reg [31:0] inter_packet_gap;
    reg [31:0] frame_start_holdoff;
    reg [31:0] payload_size;
    reg [47:0] assigned_bandwidth;
    wire wb_req;
    wire [3:0] reg_idx;

    assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign reg_idx = wb_adr_i[5:2];

    // =========================================================
    // State machine
    // =========================================================
    localparam [5:0] S_IDLE = 6'b000001;
    localparam [5:0] S_HOLD = 6'b000010;
    localparam [5:0] S_LEAD = 6'b000100;
    localparam [5:0] S_PAY = 6'b001000;
    localparam [5:0] S_TRAIL = 6'b010000;
    localparam [5:0] S_GAP = 6'b100000;

    reg [5:0] state;
    reg [5:0] after_gap;
    reg [31:0] tick_cnt;
    reg [0:0] sub_cnt;
    reg [15:0] byte_cnt;
    reg [15:0] pkt_bytes;
    reg [31:0] left_bytes;
    reg [31:0] frm_left;
    reg [15:0] pay_max;
    wire tick;
    wire [7:0] f_data;
    wire f_valid;
    reg f_pop;

    // One byte per 8 ns tick at a 4 ns clock
    assign tick = (sub_cnt == (`SPP_CLKS_PER_TICK - 1)); // [RQ6] [RQ11]
    assign frame_take_o = (state == S_IDLE) && enable && frame_ready_i;

    spp_fifo #(
        .WIDTH(8),
        .DEPTH(FIFO_DEPTH),
        .AW(FIFO_AW)
    ) u_fifo (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .in_data_i(img_data_i),
        .in_valid_i(img_valid_i),
        .in_ready_o(img_ready_o),
        .out_data_o(f_data),
        .out_valid_o(f_valid),
        .out_ready_i(f_pop)
    );

    always @*
    begin
        f_pop = (state == S_PAY) && tick && f_valid;
    end

    // =========================================================
    // Bandwidth estimate
    // =========================================================
    reg [31:0] npkts;
    reg [47:0] frame_total;
    reg [47:0] bw_num;
    reg [47:0] bw_den;
    wire [47:0] bw_q;
    wire bw_done;
    reg bw_start;

    always @*
    begin
        pay_max = stream_packet_length - `SPP_HDR_BYTES; // [RQ4]
        if (pay_max == 16'h0000)
        begin
            npkts = 32'h00000001;
        end
        else
        begin
            npkts = (payload_size + {16'h0000, pay_max} - 32'h00000001) /
                {16'h0000, pay_max};
        end
        frame_total = {16'h0000, payload_size}
            + {16'h0000, npkts} * {32'h00000000, `SPP_HDR_BYTES}
            + {32'h00000000, `SPP_LEADER_BYTES} + {32'h00000000, `SPP_TRAILER_BYTES};
        // Frame time in ticks: bytes plus a gap after each of npkts+1 packets
        bw_num = frame_total * {16'h0000, `SPP_TICKS_PER_SEC}; // [RQ14]
        bw_den = frame_total + ({16'h0000, npkts} + 48'h000000000001)
            * {16'h0000, inter_packet_gap}; // [RQ14]
    end

    // Estimate recomputed continuously so it tracks register writes
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            bw_start <= 1'b0;
            assigned_bandwidth <= 48'h000000000000;
        end
        else
        begin
            bw_start <= !bw_start;
            if (bw_done)
            begin
                assigned_bandwidth <= bw_q; // [RQ10]
            end
        end
    end

    spp_bw_div #(
        .W(48)
    ) u_div (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .start_i(bw_start),
        .num_i(bw_num),
        .den_i(bw_den),
        .quo_o(bw_q),
        .done_o(bw_done)
    );

    // =========================================================
    // Wishbone slave
    // =========================================================
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
            enable <= 1'b0;
            stream_packet_length <= `SPP_PKT_LEN_RST;
            inter_packet_gap <= `SPP_GAP_RST;
            frame_start_holdoff <= `SPP_HOLDOFF_RST;
        end
        else
        begin
            wb_ack_o <= wb_req;
            if (wb_req && wb_we_i)
            begin
                case (reg_idx)
                    `SPP_ADDR_CTRL:
                    begin
                        if (wb_sel_i[0]) enable <= wb_dat_i[`SPP_CTRL_EN];
                    end
                    `SPP_ADDR_PKT_LEN:
                    begin
                        if (wb_sel_i[0]) stream_packet_length[7:0] <= wb_dat_i[7:0]; // [RQ3]
                        if (wb_sel_i[1]) stream_packet_length[15:8] <= wb_dat_i[15:8];
                    end
                    `SPP_ADDR_GAP:
                    begin
                        if (wb_sel_i[0]) inter_packet_gap[7:0] <= wb_dat_i[7:0]; // [RQ5]
                        if (wb_sel_i[1]) inter_packet_gap[15:8] <= wb_dat_i[15:8];
                        if (wb_sel_i[2]) inter_packet_gap[23:16] <= wb_dat_i[23:16];
                        if (wb_sel_i[3]) inter_packet_gap[31:24] <= wb_dat_i[31:24];
                    end
                    `SPP_ADDR_HOLDOFF:
                    begin
                        if (wb_sel_i[0]) frame_start_holdoff[7:0] <= wb_dat_i[7:0]; // [RQ8]
                        if (wb_sel_i[1]) frame_start_holdoff[15:8] <= wb_dat_i[15:8];
                        if (wb_sel_i[2]) frame_start_holdoff[23:16] <= wb_dat_i[23:16];
                        if (wb_sel_i[3]) frame_start_holdoff[31:24] <= wb_dat_i[31:24];
                    end
                    default:
                    begin
                        enable <= enable;
                    end
                endcase
            end
            if (wb_req && !wb_we_i)
            begin
                case (reg_idx)
                    `SPP_ADDR_CTRL: wb_dat_o <= {31'h00000000, enable};
                    `SPP_ADDR_PKT_LEN: wb_dat_o <= {16'h0000, stream_packet_length};
                    `SPP_ADDR_GAP: wb_dat_o <= inter_packet_gap;
                    `SPP_ADDR_HOLDOFF: wb_dat_o <= frame_start_holdoff;
                    `SPP_ADDR_PAYLOAD: wb_dat_o <= payload_size; // [RQ1]
                    `SPP_ADDR_TICK_RATE: wb_dat_o <= `SPP_TICKS_PER_SEC; // [RQ7]
                    `SPP_ADDR_BANDWIDTH: wb_dat_o <= assigned_bandwidth[31:0]; // [RQ10]
                    `SPP_ADDR_STATUS: wb_dat_o <= {26'h0000000, state};
                    default: wb_dat_o <= 32'h00000000;
                endcase
            end
        end
    end

    // =========================================================
    // Packet sequencer
    // =========================================================
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            state <= S_IDLE;
            after_gap <= S_IDLE;
            tick_cnt <= 32'h00000000;
            sub_cnt <= 1'b0;
            byte_cnt <= 16'h0000;
            pkt_bytes <= 16'h0000;
            left_bytes <= 32'h00000000;
            frm_left <= 32'h00000000;
            payload_size <= 32'h00000000;
            tx_data_o <= 8'h00;
            tx_valid_o <= 1'b0;
            tx_sop_o <= 1'b0;
            tx_eop_o <= 1'b0;
            tx_kind_o <= 2'h0;
        end
        else
        begin
            tx_valid_o <= 1'b0;
            tx_sop_o <= 1'b0;
            tx_eop_o <= 1'b0;
            // Stall the tick while payload waits on the FIFO
            if (!(state == S_PAY && !f_valid))
            begin
                sub_cnt <= tick ? 1'b0 : sub_cnt + 1'b1;
            end
            case (state)
                S_IDLE:
                begin
                    sub_cnt <= 1'b0;
                    if (frame_take_o)
                    begin
                        payload_size <= frame_bytes_i; // [RQ1]
                        frm_left <= frame_bytes_i;
                        tick_cnt <= frame_start_holdoff; // [RQ8]
                        state <= S_HOLD;
                    end
                end
                S_HOLD:
                begin
                    if (tick_cnt == 32'h00000000)
                    begin
                        byte_cnt <= 16'h0000;
                        pkt_bytes <= `SPP_LEADER_BYTES;
                        state <= S_LEAD; // [RQ2]
                    end
                    else if (tick)
                    begin
                        tick_cnt <= tick_cnt - 32'h00000001;
                    end
                end
                S_LEAD, S_TRAIL, S_PAY:
                begin
                    if (tick && (state != S_PAY || f_valid))
                    begin
                        tx_valid_o <= 1'b1;
                        tx_sop_o <= (byte_cnt == 16'h0000);
                        tx_eop_o <= (byte_cnt == pkt_bytes - 16'h0001);
                        tx_kind_o <= (state == S_LEAD) ? 2'h0 :
                            (state == S_PAY) ? 2'h1 : 2'h2;
                        tx_data_o <= (state == S_PAY) ? f_data : 8'h00;
                        byte_cnt <= byte_cnt + 16'h0001;
                        if (byte_cnt == pkt_bytes - 16'h0001)
                        begin
                            byte_cnt <= 16'h0000;
                            tick_cnt <= inter_packet_gap; // [RQ5]
                            state <= S_GAP;
                            if (state == S_TRAIL)
                            begin
                                after_gap <= S_IDLE;
                            end
                            else
                            begin
                                // Last payload packet may be short
                                if (frm_left > {16'h0000, pay_max}) // [RQ3] [RQ4]
                                begin
                                    left_bytes <= {16'h0000, pay_max};
                                end
                                else
                                begin
                                    left_bytes <= frm_left;
                                end
                                after_gap <= (frm_left == 32'h00000000) ? S_TRAIL : S_PAY;
                            end
                        end
                    end
                end
                S_GAP:
                begin
                    if (tick_cnt == 32'h00000000)
                    begin
                        state <= after_gap;
                        if (after_gap == S_PAY)
                        begin
                            pkt_bytes <= left_bytes[15:0];
                            frm_left <= frm_left - left_bytes;
                        end
                        else
                        begin
                            pkt_bytes <= `SPP_TRAILER_BYTES; // [RQ2]
                        end
                    end
                    else if (tick)
                    begin
                        tick_cnt <= tick_cnt - 32'h00000001;
                    end
                end
                default:
                begin
                    state <= S_IDLE;
                end
            endcase
        end
    end
endmodule // spp_pacer

// *** bench/spp_pacer_chk.sv ***
`timescale 1ns/1ps
module spp_pacer_chk (
    input wire clk_i, // Clock
    input wire rst_i, // Sync reset
    input wire [31:0] wb_adr_i, // Address
    input wire [31:0] wb_dat_i, // Write data
    input wire [31:0] wb_dat_o, // Read data
    input wire wb_we_i, // Write enable
    input wire wb_cyc_i, // Cycle
    input wire wb_stb_i, // Strobe
    input wire wb_ack_o, // Acknowledge
    input wire frame_ready_i, // Frame waiting
    input wire frame_take_o, // Frame taken
    input wire tx_valid_o, // Byte valid
    input wire tx_sop_o, // First byte
    input wire tx_eop_o, // Last byte
    input wire [1:0] tx_kind_o // Packet kind
);
    // ==========================================
    // Shadow settings and timing counters
    reg [15:0] len_sh;
    reg [15:0] gap_sh;
    reg [15:0] hold_sh;
    reg [15:0] since_eop;
    reg [15:0] since_take;
    reg [15:0] cnt;
    reg [1:0] last_kind;
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            len_sh <= 16'h05DC;
            gap_sh <= 16'h0000;
            hold_sh <= 16'h0000;
            since_eop <= 16'hFFFF;
            since_take <= 16'hFFFF;
            cnt <= 16'h0000;
            last_kind <= 2'h2;
        end
        else
        begin
            if (wb_ack_o && wb_we_i && wb_adr_i[5:2] == 4'h1) len_sh <= wb_dat_i[15:0];
            if (wb_ack_o && wb_we_i && wb_adr_i[5:2] == 4'h2) gap_sh <= wb_dat_i[15:0];
            if (wb_ack_o && wb_we_i && wb_adr_i[5:2] == 4'h3) hold_sh <= wb_dat_i[15:0];
            // Saturate so a long idle never wraps into a false short gap
            if (tx_valid_o && tx_eop_o) since_eop <= 16'h0000;
            else if (since_eop != 16'hFFFF) since_eop <= since_eop + 16'h0001;
            if (frame_take_o) since_take <= 16'h0000;
            else if (since_take != 16'hFFFF) since_take <= since_take + 16'h0001;
            if (tx_valid_o) cnt <= tx_eop_o ? 16'h0000 : cnt + 16'h0001;
            if (tx_valid_o && tx_sop_o) last_kind <= tx_kind_o;
        end
    end
    // ==========================================
    // Properties
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
    ack_latency_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack late");
    rate_read_a: assert property (wb_ack_o && !wb_we_i && wb_adr_i[5:2] == 4'h5 |->
        wb_dat_o == 32'h07735940) else $error("tick rate wrong");
    tick_space_a: assert property (tx_valid_o |=> !tx_valid_o) else $error("byte faster");
    sop_first_a: assert property (tx_valid_o && tx_sop_o |-> cnt == 16'h0000)
        else $error("sop not first");
    hdr_len_a: assert property (tx_valid_o && tx_eop_o && tx_kind_o != 2'h1 |->
        cnt == 16'h0023) else $error("leader or trailer length");
    pay_len_a: assert property (tx_valid_o && tx_eop_o && tx_kind_o == 2'h1 |->
        {1'b0, cnt} + 17'h0025 <= {1'b0, len_sh}) else $error("payload too long");
    block_order_a: assert property (tx_valid_o && tx_sop_o |->
        (tx_kind_o == 2'h0) == (last_kind == 2'h2) && tx_kind_o != 2'h3) else $error("order");
    pkt_gap_a: assert property (tx_valid_o && tx_sop_o |->
        {1'b0, since_eop} >= {gap_sh, 1'b0}) else $error("gap short");
    start_hold_a: assert property (tx_valid_o && tx_sop_o && tx_kind_o == 2'h0 |->
        {1'b0, since_take} + 17'd1 >= {hold_sh, 1'b0}) else $error("holdoff short");
    take_gap_a: assert property (frame_take_o |->
        {1'b0, since_eop} >= {gap_sh, 1'b0}) else $error("take before trailer gap");
endmodule // spp_pacer_chk

bind spp_pacer spp_pacer_chk chk (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .frame_ready_i(frame_ready_i),
    .frame_take_o(frame_take_o), .tx_valid_o(tx_valid_o), .tx_sop_o(tx_sop_o),
    .tx_eop_o(tx_eop_o), .tx_kind_o(tx_kind_o));

// *** bench/spp_host_rx.sv ***
`timescale 1ns/1ps
// Receiving adapter: no back-pressure, so it only records what arrives
module spp_host_rx #(
    parameter TIMEOUT = 400 // Packet timeout in clocks, above any gap used
) (
    input wire clk_i, // Clock
    input wire rst_i, // Sync reset
    input wire [7:0] tx_data_i, // Byte
    input wire tx_valid_i, // Byte valid
    input wire tx_sop_i, // First byte
    input wire tx_eop_i, // Last byte
    input wire [1:0] tx_kind_i // Packet kind
);
    logic [7:0] pay_q[$];
    logic [1:0] kinds[$];
    int lens[$];
    int n;
    int idle;
    int late;
    bit in_blk;
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            n = 0;
            idle = 0;
            late = 0;
            in_blk = 0;
        end
        else if (tx_valid_i)
        begin
            idle = 0;
            n = tx_sop_i ? 1 : n + 1;
            if (tx_sop_i && tx_kind_i == 2'h0) in_blk = 1;
            if (tx_kind_i == 2'h1) pay_q.push_back(tx_data_i);
            if (tx_eop_i)
            begin
                kinds.push_back(tx_kind_i);
                lens.push_back(n);
                if (tx_kind_i == 2'h2) in_blk = 0;
            end
        end
        else if (in_blk)
        begin
            idle++;
            if (idle == TIMEOUT) late++;
        end
    end
endmodule // spp_host_rx

// *** bench/tb_stream_packet_pacer.sv ***
`timescale 1ns/1ps
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin num_errors++; \
    $display("unexpected %s: expected %0h, seen %0h", n, e, g); end end
module tb_stream_packet_pacer;
    reg clk_i = 0, rst_i = 1, wb_we_i = 0, wb_cyc_i = 0, wb_stb_i = 0;
    reg [31:0] wb_adr_i = 0, wb_dat_i = 0, frame_bytes_i = 0;
    reg [3:0] wb_sel_i = 0;
    reg frame_ready_i = 0, img_valid_i = 0, feed = 0;
    reg [7:0] img_data_i = 0;
    wire [31:0] wb_dat_o;
    wire wb_ack_o, frame_take_o, img_ready_o, tx_valid_o, tx_sop_o, tx_eop_o;
    wire [7:0] tx_data_o;
    wire [1:0] tx_kind_o;
    int num_errors = 0, checked = 0, seed = 32'h8ea4aeda, i, f, n, b, p, np;
    logic [7:0] exp_q[$];
    logic [31:0] rd;
    logic [7:0] got;
    int adrs[7] = '{0, 4, 8, 12, 20, 28, 32};
    logic [31:0] rstv[7] = '{32'h0, 32'h05DC, 32'h0, 32'h0, 32'h07735940, 32'h1, 32'h0};
    int lens[4] = '{40, 40, 37, 40}, gaps[4] = '{2, 0, 1, 3}, holds[4] = '{0, 5, 0, 2};
    spp_pacer dut (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_we_i(wb_we_i), .wb_sel_i(wb_sel_i), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .frame_bytes_i(frame_bytes_i),
        .frame_ready_i(frame_ready_i), .frame_take_o(frame_take_o), .img_data_i(img_data_i),
        .img_valid_i(img_valid_i), .img_ready_o(img_ready_o), .tx_data_o(tx_data_o),
        .tx_valid_o(tx_valid_o), .tx_sop_o(tx_sop_o), .tx_eop_o(tx_eop_o), .tx_kind_o(tx_kind_o));
    spp_host_rx host (.clk_i(clk_i), .rst_i(rst_i), .tx_data_i(tx_data_o),
        .tx_valid_i(tx_valid_o), .tx_sop_i(tx_sop_o), .tx_eop_i(tx_eop_o), .tx_kind_i(tx_kind_o));
    // ==========================================
    // Clock, image feeder, watchdog
    initial forever #2 clk_i = ~clk_i;
    always @(posedge clk_i)
    begin
        if (img_valid_i && img_ready_o) exp_q.push_back(img_data_i);
        if (!img_valid_i || img_ready_o)
        begin
            img_valid_i <= feed && $random(seed) % 4 != 0;
            img_data_i <= $random(seed);
        end
    end
    initial
    begin
        repeat (60000) @(posedge clk_i);
        num_errors++;
        complete_run;
    end
    // ==========================================
    // Helpers
    task automatic wb(input bit we, input int adr, input logic [31:0] dat);
        wb_cyc_i <= 1;
        wb_stb_i <= 1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_dat_i <= dat;
        wb_sel_i <= 4'hF;
        // Only the watchdog ends a wait for the acknowledge
        do
        begin
            @(posedge clk_i);
        end
        while (wb_ack_o !== 1'b1);
        rd = wb_dat_o;
        wb_cyc_i <= 0;
        wb_stb_i <= 0;
        wb_we_i <= 0;
        @(posedge clk_i);
    endtask
    function automatic int exp_len(int k, int cnt, int by, int pl);
        if (k == 0 || k == cnt - 1) return 36;
        return (k < cnt - 2) ? pl : by - pl * (cnt - 3);
    endfunction
    // Bytes per second: frame bytes over frame bytes plus gap ticks
    function automatic longint exp_bw(input longint tot, input longint gp);
        return tot * 64'h0000000007735940 / (tot + gp);
    endfunction
    task complete_run;
        $display("checked %0d, num_errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // ==========================================
    // Main sequence
    initial
    begin
        repeat (5) @(posedge clk_i);
        rst_i <= 0;
        @(posedge clk_i);
        for (i = 0; i < 7; i++)
        begin
            wb(0, adrs[i], 0);
            `CHK("reset value", rstv[i], rd)
        end
        wb(1, 20, 0);
        wb(0, 20, 0);
        `CHK("tick rate after write", 32'h07735940, rd)
        feed <= 1;
        wb(1, 0, 1);
        for (f = 0; f < 4; f++)
        begin
            // Holdoff stays zero except the staggered frames 1 and 3
            wb(1, 4, lens[f]);
            wb(1, 8, gaps[f]);
            wb(1, 12, holds[f]);
            p = lens[f] - 36;
            b = (f == 1) ? 8 : (f == 3) ? 0 : ($unsigned($random(seed)) % 20) + 1;
            np = (b + p - 1) / p + 2;
            frame_bytes_i <= b;
            frame_ready_i <= 1;
            n = 0;
            do
            begin
                @(posedge clk_i);
                n++;
            end
            while (frame_take_o !== 1'b1 && n < 5000);
            frame_ready_i <= 0;
            n = 0;
            while (host.kinds.size() < np && n < 20000)
            begin
                @(posedge clk_i);
                n++;
            end
            repeat (20) @(posedge clk_i);
            `CHK("packet count", np, host.kinds.size())
            for (i = 0; i < np && i < host.kinds.size(); i++)
            begin
                `CHK("kind", (i == 0) ? 2'h0 : (i == np - 1) ? 2'h2 : 2'h1, host.kinds[i])
                `CHK("length", exp_len(i, np, b, p), host.lens[i])
            end
            `CHK("payload bytes", b, host.pay_q.size())
            // Pop once into locals: the compare macro names its arguments twice
            while (host.pay_q.size() > 0 && exp_q.size() > 0)
            begin
                rd = exp_q.pop_front();
                got = host.pay_q.pop_front();
                `CHK("payload data", rd[7:0], got)
            end
            host.kinds.delete();
            host.lens.delete();
            host.pay_q.delete();
            wb(1, 16, 32'hFFFF);
            wb(0, 16, 0);
            `CHK("payload size", b, rd)
        end
        `CHK("host timeouts", 0, host.late)
        wb(1, 8, 0);
        repeat (300) @(posedge clk_i);
        wb(0, 24, 0);
        `CHK("bandwidth no gap", exp_bw(72, 0), rd)
        wb(1, 8, 50);
        repeat (300) @(posedge clk_i);
        wb(0, 24, 0);
        // Empty frame: leader and trailer only, one gap after the leader
        `CHK("bandwidth lowered", exp_bw(72, 50), rd)
        complete_run;
    end
endmodule // tb_stream_packet_pacer
